// [rtl/wasc_pkg.sv]
// constants and register map of the waveform auto-shutdown control block
// Contract
// - bit 7 of control reads 1 after an auto-shutdown event, else 0.
// - bit 6 of control enables automatic restart after shutdown when 1.
// - control bits 5, 4 and 0 always read zero; writes to them ignored.
// - with bit 3 set, high comparator 2 output causes shutdown.
// - with bit 2 set, high comparator 1 output causes shutdown.
// - with bit 1 set, high generator input pin causes shutdown.
// - sources with cleared enable are fully masked from the shutdown request.
package wasc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 8;
  localparam int NSRC = 3;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_SRC_LEVEL = 12'h010;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int FLAG_BIT = 7;
  localparam int RESTART_BIT = 6;
  localparam int CMP2_EN_BIT = 3;
  localparam int CMP1_EN_BIT = 2;
  localparam int PIN_EN_BIT = 1;
  localparam int SRC_EN_LSB = 1;
  localparam logic [CTRL_W-1:0] CTRL_CFG_MASK = 8'h4E;
  localparam logic [CTRL_W-1:0] CTRL_FLAG_MASK = 8'h80;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // source index order: pin, comparator 1, comparator 2
  // ----------------------------------------------------------------
  localparam int SRC_PIN = 0;
  localparam int SRC_CMP1 = 1;
  localparam int SRC_CMP2 = 2;
  localparam int SRC_GATED_LSB = 4;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int INT_W = 5;
  localparam int EV_SHUTDOWN = 0;
  localparam int EV_RESTART = 1;
  localparam int EV_SRC_LSB = 2;
  localparam logic [INT_W-1:0] INT_RESET = 5'h00;

endpackage

// [rtl/wasc_src_if.sv]
// one shutdown source between the control logic and its gate
`timescale 1ns/1ns
interface wasc_src_if;
  logic level;
  logic enable;
  logic gated;
  logic rise;

  modport gate (
    input level,
    input enable,
    output gated,
    output rise
  );

  modport user (
    output level,
    output enable,
    input gated,
    input rise
  );
endinterface

// [rtl/wasc_src_gate.sv]
// masks one shutdown source and flags its enabled rising edge
`timescale 1ns/1ns
module wasc_src_gate (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // source
  wasc_src_if.gate src
);

  logic prev_r;

  // a disabled source contributes nothing at all
  assign src.gated = src.level & src.enable;
  // edge taken on the gated level so enabling a high source also counts
  assign src.rise = src.gated & ~prev_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= src.gated;
    end
  end

endmodule

// [rtl/wasc_auto_shutdown.sv]
// auto-shutdown source selection, status flag and apb register slave
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module wasc_auto_shutdown (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [wasc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [wasc_pkg::DATA_W-1:0] i_pwdata,
  output logic o_pready,
  output logic [wasc_pkg::DATA_W-1:0] o_prdata,
  output logic o_pslverr,
  // shutdown sources, synchronous to the clock
  input wire logic i_cmp2_output_synced,
  input wire logic i_cmp1_output_synced,
  input wire logic i_generator_input_pin,
  // to the waveform generator
  output logic o_shutdown_req,
  output logic o_restart_enable,
  // interrupt
  output logic o_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [wasc_pkg::CTRL_W-1:0] cfg_r;
  logic [wasc_pkg::CTRL_W-1:0] cfg_nxt;
  logic flag_r;
  logic flag_nxt;
  logic [wasc_pkg::INT_W-1:0] int_stat_r;
  logic [wasc_pkg::INT_W-1:0] int_stat_nxt;
  logic [wasc_pkg::INT_W-1:0] int_en_r;
  logic [wasc_pkg::INT_W-1:0] int_en_nxt;
  logic pready_r;
  logic [wasc_pkg::DATA_W-1:0] prdata_r;
  logic pslverr_r;
  logic irq_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic access_done;
  logic wr_done;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic hit_src;
  logic hit_any;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;

  assign setup = i_psel & ~i_penable;
  // the slave answers in the first access cycle, so pready_r marks the end
  assign access_done = i_psel & i_penable & pready_r;
  assign wr_done = access_done & i_pwrite;

  assign hit_ctrl = (i_paddr == wasc_pkg::OFS_CTRL);
  assign hit_stat = (i_paddr == wasc_pkg::OFS_INT_STATUS);
  assign hit_clr = (i_paddr == wasc_pkg::OFS_INT_CLEAR);
  assign hit_en = (i_paddr == wasc_pkg::OFS_INT_ENABLE);
  assign hit_src = (i_paddr == wasc_pkg::OFS_SRC_LEVEL);
  assign hit_any = hit_ctrl | hit_stat | hit_clr | hit_en | hit_src;

  assign wr_ctrl = wr_done & hit_ctrl;
  assign wr_clr = wr_done & hit_clr;
  assign wr_en = wr_done & hit_en;

  // ----------------------------------------------------------------
  // shutdown sources
  // ----------------------------------------------------------------
  logic [wasc_pkg::NSRC-1:0] src_level;
  logic [wasc_pkg::NSRC-1:0] src_en;
  logic [wasc_pkg::NSRC-1:0] src_gated;
  logic [wasc_pkg::NSRC-1:0] src_rise;
  logic shut_any;
  logic restart_en;

  assign src_level[wasc_pkg::SRC_PIN] = i_generator_input_pin;
  assign src_level[wasc_pkg::SRC_CMP1] = i_cmp1_output_synced;
  assign src_level[wasc_pkg::SRC_CMP2] = i_cmp2_output_synced;
  assign src_en[wasc_pkg::SRC_PIN] = cfg_r[wasc_pkg::PIN_EN_BIT];
  assign src_en[wasc_pkg::SRC_CMP1] = cfg_r[wasc_pkg::CMP1_EN_BIT];
  assign src_en[wasc_pkg::SRC_CMP2] = cfg_r[wasc_pkg::CMP2_EN_BIT];

  for (genvar i = 0; i < wasc_pkg::NSRC; i++) begin : g_src
    wasc_src_if u_if();
    assign u_if.level = src_level[i];
    assign u_if.enable = src_en[i];
    assign src_gated[i] = u_if.gated;
    assign src_rise[i] = u_if.rise;
    wasc_src_gate u_gate (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .src(u_if.gate)
    );
  end

  // only enabled sources reach the combined request
  assign shut_any = |src_gated;
  assign restart_en = cfg_r[wasc_pkg::RESTART_BIT];

  // ----------------------------------------------------------------
  // shutdown event flag
  // ----------------------------------------------------------------
  logic sw_set;
  logic sw_clr;
  logic auto_clr;

  assign sw_set = wr_ctrl & i_pwdata[wasc_pkg::FLAG_BIT];
  assign sw_clr = wr_ctrl & ~i_pwdata[wasc_pkg::FLAG_BIT];
  // auto clear only once every enabled source has gone low
  assign auto_clr = restart_en & ~shut_any;
  // an active source wins over a software or automatic clear
  assign flag_nxt = shut_any | sw_set
                  | (flag_r & ~sw_clr & ~auto_clr);

  // unimplemented bits can never be stored
  assign cfg_nxt = wr_ctrl
                 ? (i_pwdata[wasc_pkg::CTRL_W-1:0]
                    & wasc_pkg::CTRL_CFG_MASK)
                 : cfg_r;

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  logic [wasc_pkg::INT_W-1:0] int_events;
  logic [wasc_pkg::INT_W-1:0] int_clr_mask;

  assign int_events[wasc_pkg::EV_SHUTDOWN] = flag_nxt & ~flag_r;
  assign int_events[wasc_pkg::EV_RESTART] = flag_r & ~flag_nxt & auto_clr;
  assign int_events[wasc_pkg::EV_SRC_LSB +: wasc_pkg::NSRC] = src_rise;
  assign int_clr_mask = wr_clr ? i_pwdata[wasc_pkg::INT_W-1:0]
                               : wasc_pkg::INT_RESET;
  // a new event in the clearing cycle survives the clear
  assign int_stat_nxt = (int_stat_r & ~int_clr_mask) | int_events;
  assign int_en_nxt = wr_en ? i_pwdata[wasc_pkg::INT_W-1:0] : int_en_r;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [wasc_pkg::CTRL_W-1:0] ctrl_view;
  logic [wasc_pkg::DATA_W-1:0] rd_data;

  assign ctrl_view = (cfg_r & wasc_pkg::CTRL_CFG_MASK)
                   | (flag_r ? wasc_pkg::CTRL_FLAG_MASK
                             : wasc_pkg::CTRL_RESET);
  assign rd_data =
      hit_ctrl ? {{(wasc_pkg::DATA_W-wasc_pkg::CTRL_W){1'b0}}, ctrl_view}
    : hit_stat ? {{(wasc_pkg::DATA_W-wasc_pkg::INT_W){1'b0}}, int_stat_r}
    : hit_en ? {{(wasc_pkg::DATA_W-wasc_pkg::INT_W){1'b0}}, int_en_r}
    : hit_src ? {{(wasc_pkg::DATA_W-2*wasc_pkg::NSRC-1){1'b0}},
                 src_gated, 1'b0, src_level}
    : 32'h0000_0000;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_r <= wasc_pkg::CTRL_RESET;
      flag_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      int_stat_r <= wasc_pkg::INT_RESET;
      int_en_r <= wasc_pkg::INT_RESET;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      int_en_r <= int_en_nxt;
      irq_r <= |(int_stat_nxt & int_en_nxt);
    end
  end

  // read data and error are captured in setup, answered one cycle later
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      prdata_r <= (setup & ~i_pwrite) ? rd_data : 32'h0000_0000;
      pslverr_r <= setup & ~hit_any;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_pready = pready_r;
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r;
  assign o_shutdown_req = flag_r;
  assign o_restart_enable = cfg_r[wasc_pkg::RESTART_BIT];
  assign o_irq = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_flag_reads_back;
    @(posedge i_ref_clk) disable iff (i_rst)
    (setup && !i_pwrite && hit_ctrl)
      |=> (o_prdata[wasc_pkg::FLAG_BIT] == $past(flag_r));
  endproperty
  a_flag_reads_back: assert property (p_flag_reads_back)
    else $error("status flag read back differs from flag state");

  property p_restart_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ctrl |=> (o_restart_enable == $past(i_pwdata[wasc_pkg::RESTART_BIT]));
  endproperty
  a_restart_write: assert property (p_restart_write)
    else $error("restart enable did not follow control write");

  property p_unimpl_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (setup && !i_pwrite && hit_ctrl)
      |=> (o_prdata[5:4] == 2'b00) && (o_prdata[0] == 1'b0)
          && o_pready;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented control bit read as one");

  property p_cmp2_shut;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cmp2_output_synced && cfg_r[wasc_pkg::CMP2_EN_BIT])
      |=> o_shutdown_req;
  endproperty
  a_cmp2_shut: assert property (p_cmp2_shut)
    else $error("enabled comparator 2 did not raise shutdown");

  property p_cmp1_shut;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cmp1_output_synced && cfg_r[wasc_pkg::CMP1_EN_BIT])
      |=> o_shutdown_req;
  endproperty
  a_cmp1_shut: assert property (p_cmp1_shut)
    else $error("enabled comparator 1 did not raise shutdown");

  property p_pin_shut;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_generator_input_pin && cfg_r[wasc_pkg::PIN_EN_BIT])
      |=> o_shutdown_req;
  endproperty
  a_pin_shut: assert property (p_pin_shut)
    else $error("enabled input pin did not raise shutdown");

  property p_masked;
    @(posedge i_ref_clk) disable iff (i_rst)
    (!flag_r && !wr_ctrl
     && !(i_cmp2_output_synced && cfg_r[wasc_pkg::CMP2_EN_BIT])
     && !(i_cmp1_output_synced && cfg_r[wasc_pkg::CMP1_EN_BIT])
     && !(i_generator_input_pin && cfg_r[wasc_pkg::PIN_EN_BIT]))
      |=> !o_shutdown_req;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked source raised shutdown");

  property p_auto_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flag_r && restart_en && !shut_any && !wr_ctrl) |=> !o_shutdown_req;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("flag not cleared by auto restart");

  property p_hold_flag;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flag_r && !restart_en && !wr_ctrl)
      |=> o_shutdown_req ##1 (o_shutdown_req || $past(wr_ctrl)
                              || $past(restart_en));
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("flag cleared without software while restart off");

  property p_irq_follows;
    @(posedge i_ref_clk) disable iff (i_rst)
    ($rose(o_shutdown_req) && int_en_r[wasc_pkg::EV_SHUTDOWN]
     && !wr_clr && !wr_en) |-> o_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("enabled shutdown event gave no interrupt");

  property p_flag_cause;
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_shutdown_req) |-> ($past(shut_any) || $past(sw_set));
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("shutdown flag rose with no source and no write");

  property p_sw_set;
    @(posedge i_ref_clk) disable iff (i_rst)
    (wr_ctrl && i_pwdata[wasc_pkg::FLAG_BIT]) |=> o_shutdown_req;
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("software write of the flag bit did not set it");

  property p_restart_idle;
    @(posedge i_ref_clk) disable iff (i_rst)
    (restart_en && !flag_r && !shut_any && !wr_ctrl)
      |=> !o_shutdown_req;
  endproperty
  a_restart_idle: assert property (p_restart_idle)
    else $error("flag set with restart on and no active source");

  property p_cfg_store;
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ctrl |=> (cfg_r == ($past(i_pwdata[wasc_pkg::CTRL_W-1:0])
                           & wasc_pkg::CTRL_CFG_MASK));
  endproperty
  a_cfg_store: assert property (p_cfg_store)
    else $error("control write stored an unimplemented bit");

  property p_cmp2_masked;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cmp2_output_synced && !cfg_r[wasc_pkg::CMP2_EN_BIT])
      |-> !src_gated[wasc_pkg::SRC_CMP2];
  endproperty
  a_cmp2_masked: assert property (p_cmp2_masked)
    else $error("disabled comparator 2 reached the request");

  property p_cmp1_masked;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cmp1_output_synced && !cfg_r[wasc_pkg::CMP1_EN_BIT])
      |-> !src_gated[wasc_pkg::SRC_CMP1];
  endproperty
  a_cmp1_masked: assert property (p_cmp1_masked)
    else $error("disabled comparator 1 reached the request");

  property p_pin_masked;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_generator_input_pin && !cfg_r[wasc_pkg::PIN_EN_BIT])
      |-> !src_gated[wasc_pkg::SRC_PIN];
  endproperty
  a_pin_masked: assert property (p_pin_masked)
    else $error("disabled input pin reached the request");

  property p_sw_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flag_r && sw_clr && !shut_any) |=> !o_shutdown_req;
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("software clear of the flag had no effect");

  property p_active_holds;
    @(posedge i_ref_clk) disable iff (i_rst)
    (flag_r && shut_any) |=> o_shutdown_req;
  endproperty
  a_active_holds: assert property (p_active_holds)
    else $error("flag cleared while an enabled source was high");

endmodule

// [tb/wasc_src_model.sv]
// behavioural comparators and shutdown input pin feeding the block
`timescale 1ns/1ns
module wasc_src_model (
  // clock
  input wire logic i_ref_clk,
  // requested levels: bit 2 comparator 2, bit 1 comparator 1, bit 0 pin
  input wire logic [2:0] i_level,
  // synchronised levels
  output logic o_cmp2,
  output logic o_cmp1,
  output logic o_pin
);
  // levels move only after an edge, as a synchroniser stage would
  always_ff @(posedge i_ref_clk) begin
    o_cmp2 <= i_level[2];
    o_cmp1 <= i_level[1];
    o_pin <= i_level[0];
  end
endmodule

// [tb/waveform_auto_shutdown_ctrl_bench.sv]
// self-checking bench of the auto-shutdown control block
`timescale 1ns/1ns
module waveform_auto_shutdown_ctrl_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] level = 3'h0;
  logic pready, pslverr, cmp2, cmp1, pin, shutdown_req, restart_enable, irq;
  logic [31:0] prdata;
  int mismatches = 0;
  int n_compared = 0;

  always #4 ref_clk = ~ref_clk;

  wasc_src_model wasc_src_model_inst (.i_ref_clk(ref_clk), .i_level(level),
    .o_cmp2(cmp2), .o_cmp1(cmp1), .o_pin(pin));

  wasc_auto_shutdown wasc_auto_shutdown_inst (.i_ref_clk(ref_clk),
    .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_cmp2_output_synced(cmp2),
    .i_cmp1_output_synced(cmp1), .i_generator_input_pin(pin),
    .o_shutdown_req(shutdown_req), .o_restart_enable(restart_enable),
    .o_irq(irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timeout;
    mismatches++;
    close_out;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) timeout;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask

  task automatic set_lvl(input logic [2:0] v);
    @(posedge ref_clk);
    level <= v;
  endtask

  // the flag is given a bounded number of cycles to reach its level
  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (shutdown_req !== v && n < 16) begin
      @(posedge ref_clk);
      n++;
    end
    if (shutdown_req !== v) timeout;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({29'h0, shutdown_req, restart_enable, irq}, 32'h0);
    rd_chk(wasc_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk(wasc_pkg::OFS_INT_ENABLE, 32'h0000_0000);
  endtask

  task automatic t_reserved;
    wr(wasc_pkg::OFS_CTRL, 32'h0000_00FF);
    rd_chk(wasc_pkg::OFS_CTRL, 32'h0000_004E);
    chk({31'h0, restart_enable}, 32'h1);
    wr(wasc_pkg::OFS_CTRL, 32'h0000_0031);
    rd_chk(wasc_pkg::OFS_CTRL, 32'h0000_0000);
    chk({31'h0, restart_enable}, 32'h0);
  endtask

  // each source alone enabled, the other two held high, restart off
  task automatic t_sources;
    logic [31:0] en;
    logic [31:0] lv;
    for (int i = 0; i < 3; i++) begin
      en = 32'h0000_0002 << i;
      wr(wasc_pkg::OFS_CTRL, en);
      set_lvl(~(3'h1 << i));
      cyc(5);
      chk({31'h0, shutdown_req}, 32'h0);
      set_lvl(3'h7);
      wait_req(1'b1);
      chk({31'h0, shutdown_req}, 32'h1);
      lv = 32'h0000_0007 | (32'h0000_0010 << i);
      rd_chk(wasc_pkg::OFS_SRC_LEVEL, lv);
      set_lvl(3'h0);
      cyc(5);
      chk({31'h0, shutdown_req}, 32'h1);
      rd_chk(wasc_pkg::OFS_CTRL, en | 32'h0000_0080);
      wr(wasc_pkg::OFS_CTRL, en);
      cyc(1);
      chk({31'h0, shutdown_req}, 32'h0);
    end
    // flag rises, the one automatic clear and every enabled source rise
    rd_chk(wasc_pkg::OFS_INT_STATUS, 32'h0000_001F);
  endtask

  // automatic restart, status bits, masking and clearing of the interrupt
  task automatic t_restart_irq;
    wr(wasc_pkg::OFS_INT_CLEAR, 32'h0000_001F);
    wr(wasc_pkg::OFS_INT_ENABLE, 32'h0000_0001);
    wr(wasc_pkg::OFS_CTRL, 32'h0000_0042);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    set_lvl(3'h1);
    wait_req(1'b1);
    set_lvl(3'h0);
    wait_req(1'b0);
    chk({31'h0, shutdown_req}, 32'h0);
    rd_chk(wasc_pkg::OFS_INT_STATUS, 32'h0000_0007);
    chk({31'h0, irq}, 32'h1);
    wr(wasc_pkg::OFS_INT_ENABLE, 32'h0000_0000);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(wasc_pkg::OFS_INT_ENABLE, 32'h0000_0001);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(wasc_pkg::OFS_INT_CLEAR, 32'h0000_0007);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(wasc_pkg::OFS_INT_STATUS, 32'h0000_0000);
  endtask

  // an unmapped and a misaligned address both answer with an error
  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    logic [11:0] bad [2] = '{12'h020, 12'h002};
    foreach (bad[k]) begin
      apb(1'b0, bad[k], 32'h0000_0000, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0000_0000);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence and run limit
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_reserved;
    t_sources;
    t_restart_irq;
    t_unmapped;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    timeout;
  end
endmodule
